// file: logic/acs_gain_lut.v
// Typical sense amplifier gain for each gain code
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_gain_lut (
  input wire [2:0] code,
  output reg [5:0] gain
);
  // Code 111 taken as 36, the only value left to the default
  always @* begin
    case (code)
      3'h0: gain = `ACS_GAIN_000;
      3'h1: gain = `ACS_GAIN_001;
      3'h2: gain = `ACS_GAIN_010;
      3'h3: gain = `ACS_GAIN_011;
      3'h4: gain = `ACS_GAIN_100;
      3'h5: gain = `ACS_GAIN_101;
      3'h6: gain = `ACS_GAIN_110;
      default: gain = `ACS_GAIN_111;
    endcase
  end
endmodule // acs_gain_lut

// file: logic/acs_prescaler.v
// Converter clock enable divider
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_prescaler (
  input wire clk,
  input wire rst_b,
  input wire [2:0] presc_code,
  input wire restart,
  output wire tick
);
  reg [3:0] div;
  reg [3:0] cnt_q;

  always @* begin
    case (presc_code)
      3'h0: div = `ACS_DIV_000;
      3'h1: div = `ACS_DIV_001;
      3'h2: div = `ACS_DIV_010;
      3'h3: div = `ACS_DIV_011;
      3'h4: div = `ACS_DIV_100;
      default: div = `ACS_DIV_REST;
    endcase
  end

  // Restart realigns the phase so every sequence starts on a full period
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
    end else if (restart || cnt_q == 4'h0) begin
      cnt_q <= div - 4'h1;
    end else begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign tick = (cnt_q == 4'h0) && !restart;
endmodule // acs_prescaler

// file: logic/acs_regs.vh
// Register map, field positions, reset values and timing of the sequencer
// Behaviour
// - One read-only done flag per channel, bit 13 zero
// - Byte read of done flags: live, no latching
// - Per-channel result held left-justified in 16 bits
// - Word read of result clears its done flag
// - Low byte read latches high; high read clears
// - Fixed channel map, channel 13 unimplemented
// - Channel 15 reference, nominal 8 LSB, cancels offset
// - Programmable prescaler makes converter clock from bus clock
// - Nine cycles sampling, eighteen cycles converting
// - Counter steps 15,0..14, one cycle per channel
// - Four gap cycles; counting overlaps conversion
// - Control bit 7 enables sense amplifier on channel 9
// - Control bit 3 disables charge compensation
// - Charge compensation runs in step with conversion
// - Gain codes select 7,9,10,12,14,18,24,36
// - Word or high-byte channel-select write restarts; any select write clears done flags; zero stops
// - Prescaler codes divide by 10,8,6,4,2,1,1,1
// - Sequence flag set at end, cleared by status read
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

`define ACS_OFF_SENSE 8'h3C
`define ACS_OFF_CFG 8'h80
`define ACS_OFF_STAT 8'h81
`define ACS_OFF_SEL 8'h82
`define ACS_OFF_DONE 8'h84
`define ACS_OFF_RES 8'h90
`define ACS_OFF_RES_END 8'hAF

`define ACS_SENSE_AMP_EN 7
`define ACS_SENSE_COMP_DIS 3
`define ACS_CFG_OFFSET_EN 5
`define ACS_CH_CURRENT 4'h9
`define ACS_CH_CAL 4'hF

`define ACS_SENSE_RST 8'h00
`define ACS_CFG_RST 8'h00
`define ACS_SEL_RST 16'h0000
`define ACS_DONE_RST 16'h0000
`define ACS_IMPL_MASK 16'hDFFF

`define ACS_T_SAMPLE 5'h09
`define ACS_T_CONV 5'h12
`define ACS_T_GAP 5'h04
`define ACS_CAL_NOMINAL 12'h008

`define ACS_DIV_000 4'hA
`define ACS_DIV_001 4'h8
`define ACS_DIV_010 4'h6
`define ACS_DIV_011 4'h4
`define ACS_DIV_100 4'h2
`define ACS_DIV_REST 4'h1

`define ACS_GAIN_000 6'h07
`define ACS_GAIN_001 6'h09
`define ACS_GAIN_010 6'h0A
`define ACS_GAIN_011 6'h0C
`define ACS_GAIN_100 6'h0E
`define ACS_GAIN_101 6'h12
`define ACS_GAIN_110 6'h18
`define ACS_GAIN_111 6'h24

`endif

// file: logic/acs_top.v
// Converter sequencer, result registers and current sense control
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_top (
  input wire clk,
  input wire rst_b,
  input wire [7:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_byte,
  input wire bus_wr,
  input wire bus_rd,
  output reg [15:0] bus_rdata,
  input wire [9:0] adc_data,
  output reg [3:0] mux_channel,
  output reg sample_en,
  output reg convert_en,
  output reg charge_comp_en,
  output reg sense_amp_enable,
  output reg [2:0] sense_gain_select,
  output reg [5:0] sense_gain_typ,
  output reg offset_comp_active
);
  localparam ST_IDLE = 3'h0;
  localparam ST_COUNT = 3'h1;
  localparam ST_SAMPLE = 3'h2;
  localparam ST_CONV = 3'h3;
  localparam ST_GAP = 3'h4;

  reg [7:0] sense_ctl_q;
  reg [7:0] cfg_q;
  reg [15:0] sel_q;
  reg [15:0] done_q;
  reg [15:0] done_d;
  reg seq_done_q;
  reg [2:0] st_q;
  reg [3:0] pos_q;
  reg [3:0] nxt_q;
  reg [4:0] cyc_q;
  reg [9:0] adc_s1_q;
  reg [9:0] adc_s2_q;
  reg [11:0] off_q;
  reg cal_vld_q;
  reg [15:0] res_q [0:15];
  reg [7:0] hi_latch_q;
  reg [3:0] latch_ch_q;
  reg latch_vld_q;
  integer i;
  integer j;

  wire tick;
  wire [5:0] gain_w;
  wire [7:0] wa = {bus_addr[7:1], 1'b0};
  wire res_hit = bus_addr >= `ACS_OFF_RES && bus_addr <= `ACS_OFF_RES_END;
  wire [7:0] res_off = bus_addr - `ACS_OFF_RES;
  wire [3:0] res_ch = res_off[4:1];
  wire hi_byte = bus_byte && !bus_addr[0];
  wire lo_byte = bus_byte && bus_addr[0];

  // Channel-select writes: word or high byte start, low byte stores and clears done flags without starting
  wire sel_wr = bus_wr && wa == `ACS_OFF_SEL;
  wire sel_start = sel_wr && !lo_byte;
  reg [15:0] sel_new;
  always @* begin
    sel_new = sel_q;
    if (!bus_byte)
      sel_new = bus_wdata;
    else if (bus_addr[0])
      sel_new[7:0] = bus_wdata[7:0];
    else
      sel_new[15:8] = bus_wdata[7:0];
    sel_new = sel_new & `ACS_IMPL_MASK;
  end

  acs_prescaler u_presc (
    .clk(clk),
    .rst_b(rst_b),
    .presc_code(cfg_q[2:0]),
    .restart(sel_start),
    .tick(tick)
  );

  acs_gain_lut u_gain (
    .code(sense_ctl_q[2:0]),
    .gain(gain_w)
  );

  // Position 0 is channel 15, position k is channel k-1
  wire [3:0] cur_ch = pos_q - 4'h1;
  wire offset_en = cfg_q[`ACS_CFG_OFFSET_EN];

  // Next selected channel after the current one, found during conversion
  reg [3:0] nxt_pos;
  reg nxt_found;
  reg [3:0] probe;
  always @* begin
    nxt_pos = 4'h0;
    nxt_found = 1'b0;
    probe = 4'h0;
    for (i = 15; i >= 1; i = i - 1) begin
      probe = i[3:0];
      if (probe > pos_q && sel_q[probe - 4'h1]) begin
        nxt_pos = probe;
        nxt_found = 1'b1;
      end
    end
  end

  // Offset cancel: raw minus (reference - nominal), clamped to 10 bits
  wire [11:0] raw_ext = {2'h0, adc_s2_q};
  wire [11:0] corr = raw_ext - off_q;
  reg [9:0] corr_sat;
  always @* begin
    if (corr[11])
      corr_sat = 10'h000;
    else if (corr[10])
      corr_sat = 10'h3FF;
    else
      corr_sat = corr[9:0];
  end
  wire use_off = offset_en && cal_vld_q && cur_ch != `ACS_CH_CAL;
  wire [9:0] result_val = use_off ? corr_sat : adc_s2_q;
  wire conv_end = tick && st_q == ST_CONV && cyc_q == `ACS_T_CONV - 5'h1;

  // Analog result is not on this clock; two stages before use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_s1_q <= 10'h000;
      adc_s2_q <= 10'h000;
    end else begin
      adc_s1_q <= adc_data;
      adc_s2_q <= adc_s1_q;
    end
  end

  // Sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      pos_q <= 4'h0;
      nxt_q <= 4'h0;
      cyc_q <= 5'h00;
      off_q <= 12'h000;
      cal_vld_q <= 1'b0;
      for (j = 0; j < 16; j = j + 1)
        res_q[j] <= 16'h0000;
    end else if (sel_start) begin
      st_q <= (sel_new == 16'h0000) ? ST_IDLE : ST_COUNT;
      pos_q <= 4'h0;
      cyc_q <= 5'h00;
      cal_vld_q <= 1'b0;
    end else if (tick) begin
      case (st_q)
        ST_COUNT: begin
          if (sel_q[cur_ch]) begin
            st_q <= ST_SAMPLE;
            cyc_q <= 5'h00;
          end else if (pos_q == 4'hF) begin
            st_q <= ST_IDLE;
          end else begin
            pos_q <= pos_q + 4'h1;
          end
        end
        ST_SAMPLE: begin
          if (cyc_q == `ACS_T_SAMPLE - 5'h1) begin
            st_q <= ST_CONV;
            cyc_q <= 5'h00;
          end else begin
            cyc_q <= cyc_q + 5'h01;
          end
        end
        ST_CONV: begin
          if (cyc_q == `ACS_T_CONV - 5'h1) begin
            res_q[cur_ch] <= {result_val, 6'h00};
            if (cur_ch == `ACS_CH_CAL && offset_en) begin
              off_q <= raw_ext - `ACS_CAL_NOMINAL;
              cal_vld_q <= 1'b1;
            end
            cyc_q <= 5'h00;
            nxt_q <= nxt_pos;
            st_q <= nxt_found ? ST_GAP : ST_IDLE;
          end else begin
            cyc_q <= cyc_q + 5'h01;
          end
        end
        ST_GAP: begin
          if (cyc_q == `ACS_T_GAP - 5'h1) begin
            pos_q <= nxt_q;
            st_q <= ST_SAMPLE;
            cyc_q <= 5'h00;
          end else begin
            cyc_q <= cyc_q + 5'h01;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Done flags: a finishing conversion wins over a clearing read
  wire rd_res_clr = bus_rd && res_hit && !lo_byte;
  always @* begin
    done_d = done_q;
    if (sel_wr)
      done_d = `ACS_DONE_RST;
    else if (rd_res_clr)
      done_d[res_ch] = 1'b0;
    if (conv_end)
      done_d[cur_ch] = 1'b1;
    done_d = done_d & `ACS_IMPL_MASK;
  end

  wire stat_rd = bus_rd && ((bus_byte && bus_addr == `ACS_OFF_STAT) ||
    (!bus_byte && wa == `ACS_OFF_CFG));

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= `ACS_DONE_RST;
      seq_done_q <= 1'b0;
    end else begin
      done_q <= done_d;
      if (conv_end && !nxt_found)
        seq_done_q <= 1'b1;
      else if (stat_rd || sel_start)
        seq_done_q <= 1'b0;
    end
  end

  // Control registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_ctl_q <= `ACS_SENSE_RST;
      cfg_q <= `ACS_CFG_RST;
      sel_q <= `ACS_SEL_RST;
    end else if (bus_wr) begin
      if (wa == `ACS_OFF_SENSE)
        sense_ctl_q <= bus_wdata[7:0] & 8'h8F;
      if (wa == `ACS_OFF_CFG && !lo_byte)
        cfg_q <= bus_byte ? bus_wdata[7:0] : bus_wdata[15:8];
      if (sel_wr)
        sel_q <= sel_new;
    end
  end

  // High byte latch for byte-wise result reads
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_latch_q <= 8'h00;
      latch_ch_q <= 4'h0;
      latch_vld_q <= 1'b0;
    end else if (bus_rd && res_hit && bus_byte) begin
      if (bus_addr[0]) begin
        hi_latch_q <= res_q[res_ch][15:8];
        latch_ch_q <= res_ch;
        latch_vld_q <= 1'b1;
      end else begin
        latch_vld_q <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe, zero when unmapped
  reg [15:0] word_val;
  reg [7:0] status_val;
  always @* begin
    status_val = {seq_done_q, 3'h0, cur_ch};
    word_val = 16'h0000;
    if (res_hit)
      word_val = res_q[res_ch];
    else
      case (wa)
        `ACS_OFF_SENSE: word_val = {8'h00, sense_ctl_q};
        `ACS_OFF_CFG: word_val = {cfg_q, status_val};
        `ACS_OFF_SEL: word_val = sel_q;
        `ACS_OFF_DONE: word_val = done_q;
        default: word_val = 16'h0000;
      endcase
    if (hi_byte && res_hit && latch_vld_q && latch_ch_q == res_ch)
      word_val[15:8] = hi_latch_q;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      if (!bus_byte)
        bus_rdata <= word_val;
      else if (wa == `ACS_OFF_SENSE)
        bus_rdata <= bus_addr[0] ? 16'h0000 : {8'h00, sense_ctl_q};
      else
        bus_rdata <= {8'h00, bus_addr[0] ? word_val[7:0] : word_val[15:8]};
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // Analog side controls
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_channel <= 4'hF;
      sample_en <= 1'b0;
      convert_en <= 1'b0;
      charge_comp_en <= 1'b0;
      sense_amp_enable <= 1'b0;
      sense_gain_select <= 3'h0;
      sense_gain_typ <= `ACS_GAIN_000;
      offset_comp_active <= 1'b0;
    end else begin
      mux_channel <= cur_ch;
      sample_en <= st_q == ST_SAMPLE;
      convert_en <= st_q == ST_CONV;
      sense_amp_enable <= sense_ctl_q[`ACS_SENSE_AMP_EN];
      // Only while the sense channel is being sampled or converted
      charge_comp_en <= !sense_ctl_q[`ACS_SENSE_COMP_DIS] &&
        sense_ctl_q[`ACS_SENSE_AMP_EN] &&
        cur_ch == `ACS_CH_CURRENT &&
        (st_q == ST_SAMPLE || st_q == ST_CONV);
      sense_gain_select <= sense_ctl_q[2:0];
      sense_gain_typ <= gain_w;
      offset_comp_active <= use_off;
    end
  end
endmodule // acs_top

// file: tb/acs_chk_sva.sv
// Timing and control checks on the sequencer ports
`timescale 1ns/1ps
module acs_chk (
  input wire clk,
  input wire rst_b,
  input wire [7:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_byte,
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_rdata,
  input wire [3:0] mux_channel,
  input wire sample_en,
  input wire convert_en,
  input wire charge_comp_en,
  input wire sense_amp_enable,
  input wire [2:0] sense_gain_select
);
  reg [2:0] ab_q;
  reg [7:0] s_q;
  reg [7:0] sl_q;
  reg [7:0] c_q;
  wire sel_wr = bus_wr && bus_addr[7:1] == 7'h41;
  // Word and high-byte select writes abort a sequence, so timing is not judged around any select write
  wire ab = sel_wr || (|ab_q);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ab_q <= 3'h0;
      s_q <= 8'h00;
      sl_q <= 8'h00;
      c_q <= 8'h00;
    end else begin
      ab_q <= {ab_q[1:0], sel_wr};
      s_q <= sample_en ? s_q + 8'h01 : 8'h00;
      c_q <= convert_en ? c_q + 8'h01 : 8'h00;
      if (!sample_en && s_q != 8'h00)
        sl_q <= s_q;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b || ab);
  sample_len_a:
  assert property ($fell(sample_en) |->
    s_q >= 8'h09 && s_q % 8'h09 == 8'h00)
    else $error("sampling too short");
  conv_next_a:
  assert property ($fell(sample_en) |-> convert_en)
    else $error("no conversion after sampling");
  conv_len_a:
  assert property ($fell(convert_en) |-> c_q == {sl_q[6:0], 1'b0})
    else $error("conversion not twice sampling");
  gap_min_a:
  assert property ($fell(convert_en) |-> (!sample_en) [*4])
    else $error("gap too short");
  no_unimpl_a:
  assert property (sample_en |-> mux_channel != 4'hD)
    else $error("unimplemented channel sampled");
  comp_chan_a:
  assert property (charge_comp_en |-> mux_channel == 4'h9 && sense_amp_enable)
    else $error("charge compensation off channel");
  bit13_zero_a:
  assert property ($past(bus_rd) && !$past(bus_byte) && $past(bus_addr) ==
    8'h84 |-> !bus_rdata[13])
    else $error("done bit 13 set");
  amp_ctrl_a:
  assert property (bus_wr && bus_byte && bus_addr == 8'h3C |-> ##2
    sense_amp_enable == $past(bus_wdata[7], 2) &&
    sense_gain_select == $past(bus_wdata[2:0], 2))
    else $error("sense control not applied");
  cover property ($fell(convert_en));
  cover property (charge_comp_en);
  cover property ($past(bus_rd) && bus_rdata != 16'h0000);
endmodule // acs_chk

bind acs_top acs_chk u_chk (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_byte(bus_byte), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mux_channel(mux_channel),
  .sample_en(sample_en), .convert_en(convert_en),
  .charge_comp_en(charge_comp_en), .sense_amp_enable(sense_amp_enable),
  .sense_gain_select(sense_gain_select));

// file: tb/acs_core_model.sv
// Behavioural analog core: one value per channel while it is held
`timescale 1ns/1ps
module acs_core_model (
  input wire clk,
  input wire [3:0] mux_channel,
  input wire sample_en,
  input wire convert_en,
  input wire [9:0] salt,
  output reg [9:0] adc_data
);
  initial adc_data = 10'h000;
  // Outside sampling and conversion the value churns so stale capture shows
  always @(posedge clk) begin
    if (sample_en || convert_en)
      adc_data <= salt ^ {6'h00, mux_channel};
    else
      adc_data <= ~adc_data;
  end
endmodule // acs_core_model

// file: tb/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
  localparam [47:0] GT = {6'h24, 6'h18, 6'h12, 6'h0E, 6'h0C, 6'h0A,
    6'h09, 6'h07};
  localparam [31:0] DV = {4'h1, 4'h1, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA};
  reg clk = 1'b0, rst_b = 1'b0, bus_byte = 1'b0;
  reg bus_wr = 1'b0, bus_rd = 1'b0;
  reg [7:0] bus_addr = 8'h00, v;
  reg [15:0] bus_wdata = 16'h0000, d;
  reg [9:0] salt = 10'h000, s1, r;
  wire [9:0] adc_data;
  wire [15:0] bus_rdata;
  wire [3:0] mux_channel;
  wire sample_en, convert_en, charge_comp_en, sense_amp_enable;
  wire offset_comp_active;
  wire [2:0] sense_gain_select;
  wire [5:0] sense_gain_typ;
  integer mismatches = 0, n_checks = 0, cyc = 0, samp_n = 0, cc_n = 0, g;
  integer oc_n = 0;

  always #2.5 clk = ~clk;

  acs_top dut (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_byte(bus_byte), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .adc_data(adc_data),
    .mux_channel(mux_channel), .sample_en(sample_en),
    .convert_en(convert_en), .charge_comp_en(charge_comp_en),
    .sense_amp_enable(sense_amp_enable),
    .sense_gain_select(sense_gain_select),
    .sense_gain_typ(sense_gain_typ),
    .offset_comp_active(offset_comp_active));

  acs_core_model core (.clk(clk), .mux_channel(mux_channel),
    .sample_en(sample_en), .convert_en(convert_en), .salt(salt),
    .adc_data(adc_data));

  function [9:0] raw(input [3:0] c);
    raw = salt ^ {6'h00, c};
  endfunction

  function [15:0] ofs(input [9:0] x, input [9:0] c);
    integer t;
    begin
      t = x - (c - 8);
      if (t < 0)
        t = 0;
      if (t > 1023)
        t = 1023;
      ofs = {t[9:0], 6'h00};
    end
  endfunction

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [15:0] x, input b);
    begin
      bus_addr <= a;
      bus_wdata <= x;
      bus_byte <= b;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rd(input [7:0] a, input b, output [15:0] q);
    begin
      bus_addr <= a;
      bus_byte <= b;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      q = bus_rdata;
      @(posedge clk);
    end
  endtask

  task rc(input [7:0] a, input b, input [15:0] e);
    reg [15:0] q;
    begin
      rd(a, b, q);
      chk(q, e);
    end
  endtask

  // Polls without side effects: done flags are not cleared by reading
  task wait_done(input [15:0] m);
    integer i;
    begin
      d = 16'h0000;
      for (i = 0; i < 600 && d !== m; i = i + 1)
        rd(8'h84, 1'b0, d);
      chk(d, m);
    end
  endtask

  always @(negedge clk) begin
    samp_n = samp_n + sample_en;
    cc_n = cc_n + charge_comp_en;
    oc_n = oc_n + offset_comp_active;
    cyc = cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  initial begin
    d = $urandom(22973);
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc(8'h3C, 1'b1, 16'h0000);
    wr(8'h84, 16'hFFFF, 1'b0);
    wr(8'h00, 16'hFFFF, 1'b0);
    rc(8'h84, 1'b0, 16'h0000);
    rc(8'h00, 1'b0, 16'h0000);
    for (g = 0; g < 8; g = g + 1) begin
      v = $urandom;
      v[2:0] = g[2:0];
      wr(8'h3C, {8'h00, v}, 1'b1);
      rc(8'h3C, 1'b1, {8'h00, v & 8'h8F});
      chk(sense_amp_enable, v[7]);
      chk(sense_gain_typ, GT[g*6 +: 6]);
      chk(sense_gain_select, g[2:0]);
    end
    wr(8'h3C, 16'h0088, 1'b1);
    for (g = 0; g < 8; g = g + 1) begin
      s1 = $urandom;
      salt <= s1;
      wr(8'h80, {13'h0000, g[2:0]}, 1'b1);
      samp_n = 0;
      cc_n = 0;
      wr(8'h82, 16'h1200, 1'b0);
      wait_done(16'h1200);
      chk(samp_n, 18 * DV[g*4 +: 4]);
      chk(cc_n, 0);
    end
    wr(8'h3C, 16'h0080, 1'b1);
    wr(8'h80, 16'h0005, 1'b1);
    salt <= $urandom;
    samp_n = 0;
    cc_n = 0;
    wr(8'h82, 16'hA601, 1'b0);
    wait_done(16'h8601);
    chk(samp_n, 36);
    chk(cc_n > 0, 1);
    chk(oc_n, 0);
    rc(8'h85, 1'b1, 16'h0001);
    rc(8'h84, 1'b1, 16'h0086);
    rd(8'h81, 1'b1, d);
    chk(d[7], 1'b1);
    rd(8'h81, 1'b1, d);
    chk(d[7], 1'b0);
    rc(8'hAE, 1'b0, {raw(4'hF), 6'h00});
    rc(8'h84, 1'b0, 16'h0601);
    r = raw(4'hA);
    rc(8'hA5, 1'b1, {8'h00, r[1:0], 6'h00});
    rc(8'h84, 1'b0, 16'h0601);
    rc(8'hA4, 1'b1, {8'h00, r[9:2]});
    rc(8'h84, 1'b0, 16'h0201);
    r = s1 ^ 10'h00C;
    rc(8'hA8, 1'b0, {r, 6'h00});
    wr(8'h80, 16'h0025, 1'b1);
    wr(8'h82, 16'h8400, 1'b0);
    wait_done(16'h8400);
    rc(8'hA4, 1'b0, ofs(raw(4'hA), raw(4'hF)));
    chk(oc_n > 0, 1);
    wr(8'h82, 16'h0000, 1'b0);
    rc(8'h84, 1'b0, 16'h0000);
    // Low byte stores without starting; high byte write starts the sequence
    wr(8'h83, 16'h0004, 1'b1);
    samp_n = 0;
    repeat (60) @(posedge clk);
    chk(samp_n, 0);
    rc(8'h82, 1'b0, 16'h0004);
    wr(8'h82, 16'h0000, 1'b1);
    wait_done(16'h0004);
    rc(8'h94, 1'b0, {raw(4'h2), 6'h00});
    rd(8'h80, 1'b0, d);
    chk(d[7], 1'b1);
    rd(8'h81, 1'b1, d);
    chk(d[7], 1'b0);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc(8'h94, 1'b0, 16'h0000);
    rc(8'h3C, 1'b1, 16'h0000);
    chk(sense_amp_enable, 1'b0);
    give_verdict;
  end
endmodule // tb_top
